// ### shared/acs_pkg.sv
// Constants and types shared by the conversion sequencer files
package acs_pkg;

  // Result widths of the two resolution modes
  localparam int RES_HI    = 12;
  localparam int RES_LO    = 8;
  // Converter clock ticks per conversion pass
  localparam int TICKS_HI  = 52;
  localparam int TICKS_LO  = 32;
  // Sampling ticks before the first bit decision
  localparam int SMP_HI    = 16;
  localparam int SMP_LO    = 8;
  // Converter clock ticks spent on each bit decision
  localparam int TPB       = 3;
  // Base clock cycles of the load tail per pass
  localparam int TAIL_CYC  = 2;
  // Base clock cycles in one system cycle time
  localparam int SUB_PER_CYC = 3;
  // Clock rate of the base clock
  localparam int CLK_HZ    = 25_000_000;

  // Converter clock divider selections and their ratios
  localparam logic [1:0] DIV_SEL_8  = 2'h0;
  localparam logic [1:0] DIV_SEL_16 = 2'h1;
  localparam logic [1:0] DIV_SEL_32 = 2'h2;
  localparam int DIV_8     = 8;
  localparam int DIV_16    = 16;
  localparam int DIV_32    = 32;
  localparam int DIV_W     = 6;

  // Counter widths
  localparam int TICK_W    = 7;
  localparam int CYC_W     = 13;

  // SAR start code, last decision bit per mode, and result reset value
  localparam logic [RES_HI-1:0] SAR_MSB   = 12'h800;
  localparam logic [RES_HI-1:0] LSB_HI    = 12'h001;
  localparam logic [RES_HI-1:0] LSB_LO    = 12'h010;
  localparam logic [RES_HI-1:0] RES_RST   = 12'h000;

  // Conversion configuration captured at start
  typedef struct packed {
    logic       mode_hi;
    logic [1:0] div_sel;
  } acs_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_TAIL
  } acs_state_t;

endpackage

// ### verilog/acs_clk_div.sv
// Converter clock divider producing a one-cycle tick enable
`timescale 1ns/1ps
module acs_clk_div (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       clr_i,
  input  wire logic [1:0] sel_i,
  // Tick out
  output logic            tick_o
);

  logic [acs_pkg::DIV_W-1:0] cnt_r;
  logic [acs_pkg::DIV_W-1:0] last;

  // Divider ratio decode, unused code falls back to the slowest
  always_comb begin
    unique case (sel_i)
      acs_pkg::DIV_SEL_8:  last = acs_pkg::DIV_W'(acs_pkg::DIV_8 - 1);
      acs_pkg::DIV_SEL_16: last = acs_pkg::DIV_W'(acs_pkg::DIV_16 - 1);
      default:             last = acs_pkg::DIV_W'(acs_pkg::DIV_32 - 1);
    endcase
  end

  assign tick_o = !clr_i && (cnt_r == last);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i || tick_o) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  chk_tick_spacing : assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tick_o && !clr_i) |=> (!tick_o) [*7])
    else $error("divider tick closer than eight cycles");

endmodule // acs_clk_div

// ### verilog/acs_sequencer.sv
// Successive approximation conversion sequencer, top level
// Function
// - The converter offers a 12-bit result mode and an 8-bit result mode.
// - A 12-bit conversion lasts 52*N+2 base cycles for a 1/N divider.
// - An 8-bit conversion lasts 32*N+2 base cycles for a 1/N divider.
// - The converter clock divider is programmable to 1/8, 1/16 and 1/32.
// - Conversion time runs from the accepted start to the result load.
// - The first 12-bit conversion after reset takes twice as long.
// - The first conversion after leaving 8-bit mode takes twice as long.
`timescale 1ns/1ps
module acs_sequencer (
  // Clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          RST_I,
  // Control from the core
  input  wire logic                          START_I,
  input  wire logic                          ACK_I,
  input  wire acs_pkg::acs_cfg_t             CFG_I,
  // Analog comparator, asynchronous
  input  wire logic                          COMP_I,
  // Analog front end control
  output logic                               SAMPLE_O,
  output logic [acs_pkg::RES_HI-1:0]         DAC_CODE_O,
  // Status and result
  output logic                               BUSY_O,
  output logic                               DONE_O,
  output logic [acs_pkg::RES_HI-1:0]         RESULT_O
);

  acs_pkg::acs_state_t         state_r;
  acs_pkg::acs_cfg_t           cfg_r;
  logic [acs_pkg::TICK_W-1:0]  ptick_r;
  logic [acs_pkg::TICK_W-1:0]  last_tick;
  logic [acs_pkg::TICK_W-1:0]  smp_ticks;
  logic                        pass_r;
  logic                        dbl_r;
  logic                        pend_r;
  logic [2:0]                  tail_r;
  logic [2:0]                  tail_last;
  logic [1:0]                  phase_r;
  logic [acs_pkg::RES_HI-1:0]  sar_r;
  logic [acs_pkg::RES_HI-1:0]  bit_r;
  logic [acs_pkg::RES_HI-1:0]  lsb;
  logic                        comp_s1_r;
  logic                        comp_s2_r;
  logic                        comp_s3_r;
  logic                        comp_q_r;
  logic                        done_r;
  logic [acs_pkg::RES_HI-1:0]  result_r;
  logic                        tick;
  logic                        start_acc;
  logic                        load;
  logic                        decide;

  assign start_acc = (state_r == acs_pkg::ST_IDLE) && START_I;
  assign load      = (state_r == acs_pkg::ST_TAIL) && (tail_r == tail_last);

  // Pass geometry of the captured mode
  always_comb begin
    if (cfg_r.mode_hi) begin
      last_tick = acs_pkg::TICK_W'(acs_pkg::TICKS_HI - 1);
      smp_ticks = acs_pkg::TICK_W'(acs_pkg::SMP_HI);
      lsb       = acs_pkg::LSB_HI;
    end else begin
      last_tick = acs_pkg::TICK_W'(acs_pkg::TICKS_LO - 1);
      smp_ticks = acs_pkg::TICK_W'(acs_pkg::SMP_LO);
      lsb       = acs_pkg::LSB_LO;
    end
    // Tail of two cycles, four when the conversion is doubled
    tail_last = dbl_r ? 3'(2 * acs_pkg::TAIL_CYC - 1)
                      : 3'(acs_pkg::TAIL_CYC - 1);
  end

  acs_clk_div u_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .clr_i  (state_r != acs_pkg::ST_CONV),
    .sel_i  (cfg_r.div_sel),
    .tick_o (tick)
  );

  // Sequencing: sample and bit ticks per pass, then the load tail
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= acs_pkg::ST_IDLE;
      cfg_r   <= '0;
      dbl_r   <= 1'b0;
      pass_r  <= 1'b0;
      ptick_r <= '0;
      tail_r  <= '0;
    end else begin
      unique case (state_r)
        acs_pkg::ST_IDLE: begin
          if (START_I) begin
            state_r <= acs_pkg::ST_CONV;
            cfg_r   <= CFG_I;
            dbl_r   <= CFG_I.mode_hi && pend_r;
            pass_r  <= 1'b0;
            ptick_r <= '0;
          end
        end
        acs_pkg::ST_CONV: begin
          if (tick) begin
            if (ptick_r == last_tick) begin
              ptick_r <= '0;
              if (pass_r == dbl_r) begin
                state_r <= acs_pkg::ST_TAIL;
                tail_r  <= '0;
              end else begin
                pass_r <= 1'b1;
              end
            end else begin
              ptick_r <= ptick_r + 1'b1;
            end
          end
        end
        acs_pkg::ST_TAIL: begin
          if (tail_r == tail_last) begin
            state_r <= acs_pkg::ST_IDLE;
          end else begin
            tail_r <= tail_r + 1'b1;
          end
        end
      endcase
    end
  end

  // Doubling pending after reset or after any time in 8-bit mode
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pend_r <= 1'b1;
    end else if (!CFG_I.mode_hi) begin
      pend_r <= 1'b1;
    end else if (start_acc) begin
      pend_r <= 1'b0;
    end
  end

  // Comparator synchroniser, change taken when stages two and three agree
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      comp_s3_r <= 1'b0;
      comp_q_r  <= 1'b0;
    end else begin
      comp_s1_r <= COMP_I;
      comp_s2_r <= comp_s1_r;
      comp_s3_r <= comp_s2_r;
      if (comp_s2_r == comp_s3_r) begin
        comp_q_r <= comp_s3_r;
      end
    end
  end

  assign decide = (state_r == acs_pkg::ST_CONV) && tick &&
                  (ptick_r >= smp_ticks) &&
                  (phase_r == 2'(acs_pkg::TPB - 1));

  // Successive approximation register, MSB first
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sar_r   <= '0;
      bit_r   <= '0;
      phase_r <= '0;
    end else if ((state_r == acs_pkg::ST_CONV) && tick) begin
      if (ptick_r == smp_ticks - 1'b1) begin
        sar_r   <= acs_pkg::SAR_MSB;
        bit_r   <= acs_pkg::SAR_MSB;
        phase_r <= '0;
      end else if (decide) begin
        phase_r <= '0;
        // Comparator low means the trial code is above the input
        if (bit_r == lsb) begin
          sar_r <= comp_q_r ? sar_r : (sar_r & ~bit_r);
          bit_r <= '0;
        end else begin
          sar_r <= (comp_q_r ? sar_r : (sar_r & ~bit_r)) | (bit_r >> 1);
          bit_r <= bit_r >> 1;
        end
      end else if (ptick_r >= smp_ticks) begin
        phase_r <= phase_r + 1'b1;
      end
    end
  end

  // Result load and completion flag; a new completion beats a clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      result_r <= acs_pkg::RES_RST;
      done_r   <= 1'b0;
    end else begin
      if (load) begin
        result_r <= cfg_r.mode_hi ?
                    sar_r : {4'h0, sar_r[acs_pkg::RES_HI-1:4]};
        done_r   <= 1'b1;
      end else if (ACK_I || start_acc) begin
        done_r   <= 1'b0;
      end
    end
  end

  assign SAMPLE_O   = (state_r == acs_pkg::ST_CONV) && (ptick_r < smp_ticks);
  assign DAC_CODE_O = sar_r;
  assign BUSY_O     = (state_r != acs_pkg::ST_IDLE);
  assign DONE_O     = done_r;
  assign RESULT_O   = result_r;

  // Elapsed cycles since the accepted start, for the duration checks
  logic [acs_pkg::CYC_W-1:0] cyc_r;
  logic [acs_pkg::CYC_W-1:0] ratio;
  logic [acs_pkg::CYC_W-1:0] base_len;

  always_ff @(posedge CLK_I) begin
    if (RST_I || start_acc) begin
      cyc_r <= '0;
    end else if (BUSY_O) begin
      cyc_r <= cyc_r + 1'b1;
    end
  end

  always_comb begin
    unique case (cfg_r.div_sel)
      acs_pkg::DIV_SEL_8:  ratio = acs_pkg::CYC_W'(acs_pkg::DIV_8);
      acs_pkg::DIV_SEL_16: ratio = acs_pkg::CYC_W'(acs_pkg::DIV_16);
      default:             ratio = acs_pkg::CYC_W'(acs_pkg::DIV_32);
    endcase
    base_len = acs_pkg::CYC_W'(ratio * acs_pkg::CYC_W'(last_tick + 1'b1)
                               + acs_pkg::CYC_W'(acs_pkg::TAIL_CYC));
  end

  chk_len_hi_normal : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    (load && cfg_r.mode_hi && !dbl_r) |-> (cyc_r == base_len - 1'b1))
    else $error("12-bit conversion length wrong");

  chk_len_lo_normal : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    (load && !cfg_r.mode_hi) |-> (cyc_r == base_len - 1'b1))
    else $error("8-bit conversion length wrong");

  chk_len_doubled : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    (load && dbl_r) |->
      (cyc_r == acs_pkg::CYC_W'(2 * base_len - 1'b1)))
    else $error("doubled conversion length wrong");

  chk_switch_doubles : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    (!CFG_I.mode_hi ##1 (start_acc && CFG_I.mode_hi)) |=> dbl_r)
    else $error("conversion after 8-bit mode not doubled");

  chk_start_busy : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    start_acc |=> (BUSY_O && !DONE_O) [*8])
    else $error("start not followed by busy");

  // Result moves on the load edge, so its hold is judged one cycle later
  chk_done_flag : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    load |=> (DONE_O && !BUSY_O) ##1 $stable(RESULT_O))
    else $error("completion did not set done and clear busy");

  chk_lo_result_width : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    (load && !cfg_r.mode_hi) |=>
      (RESULT_O[acs_pkg::RES_HI-1:acs_pkg::RES_LO] == 4'h0))
    else $error("8-bit result wider than 8 bits");

  chk_dbl_after_reset : assert property (@(posedge CLK_I)
    disable iff (RST_I)
    (start_acc && CFG_I.mode_hi && pend_r) |=> (dbl_r && !pass_r))
    else $error("pending doubling not applied");

endmodule // acs_sequencer

// ### verification/acs_analog_model.sv
// Ideal analog comparator facing the sequencer's trial code
`timescale 1ns/1ps
module acs_analog_model (
  // Held analog level and trial code
  input  wire logic [acs_pkg::RES_HI-1:0] level_i,
  input  wire logic [acs_pkg::RES_HI-1:0] code_i,
  // Comparator decision, asynchronous
  output logic                            comp_o
);
  // Settles a few ns after the code moves, never on the clock edge
  assign #5 comp_o = (level_i >= code_i);
endmodule // acs_analog_model

// ### verification/tb_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              start = 1'b0;
  logic              ack = 1'b0;
  acs_pkg::acs_cfg_t cfg = '{1'b1, 2'h0};
  logic              comp;
  logic              sample;
  logic              busy;
  logic              done;
  logic [11:0]       dac;
  logic [11:0]       result;
  logic [11:0]       level = 12'h000;
  int                err_count = 0;
  int                compares = 0;

  always #20 clk = ~clk;

  acs_sequencer dut_u (
    .CLK_I(clk), .RST_I(rst), .START_I(start), .ACK_I(ack), .CFG_I(cfg),
    .COMP_I(comp), .SAMPLE_O(sample), .DAC_CODE_O(dac), .BUSY_O(busy),
    .DONE_O(done), .RESULT_O(result)
  );

  acs_analog_model model_u (.level_i(level), .code_i(dac), .comp_o(comp));

  task automatic chk_num(input string nm, input int exp, input int got);
    compares++;
    if (exp != got) begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic chk_sig(input string nm, input logic [11:0] exp,
                         input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One conversion; a refused start is pulsed in mid-run
  task automatic run_conv(input logic hi, input logic [1:0] sel,
                          input logic [11:0] lv, output int n);
    level = lv;
    @(posedge clk);
    start <= 1'b1;
    cfg   <= '{hi, sel};
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk_sig("busy after start", 12'h001, {11'h0, busy});
    chk_sig("done after start", 12'h000, {11'h0, done});
    chk_sig("sample after start", 12'h001, {11'h0, sample});
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 100) begin
        start <= 1'b1;
        cfg   <= '{hi, sel ^ 2'h1};
      end else if (n == 101) begin
        start <= 1'b0;
        cfg   <= '{hi, sel};
      end
      #1;
    end while (done !== 1'b1 && n < 4000);
    chk_sig("busy at load", 12'h000, {11'h0, busy});
    chk_sig("sample at load", 12'h000, {11'h0, sample});
    chk_sig("code at load", hi ? lv : {lv[11:4], 4'h0}, dac);
    chk_sig("result", hi ? lv : {4'h0, lv[11:4]}, result);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1;
    chk_sig("done after ack", 12'h000, {11'h0, done});
  endtask

  task automatic test_first_hi();
    int n;
    run_conv(1'b1, 2'h0, 12'hA5C, n);
    chk_num("first 12-bit length", 2 * (52 * 8 + 2), n);
    $display("test first_hi finished");
  endtask

  task automatic test_plain_hi();
    int n;
    run_conv(1'b1, 2'h0, 12'h3C1, n);
    chk_num("12-bit length div 8", 52 * 8 + 2, n);
    run_conv(1'b1, 2'h2, 12'hFFF, n);
    chk_num("12-bit length div 32", 52 * 32 + 2, n);
    $display("test plain_hi finished");
  endtask

  task automatic test_lo_divs();
    int n;
    int ratio [4] = '{8, 16, 32, 32};
    logic [11:0] lv [4] = '{12'h3B7, 12'hFF0, 12'h000, 12'h80F};
    for (int i = 0; i < 4; i++) begin
      run_conv(1'b0, i[1:0], lv[i], n);
      chk_num("8-bit length", 32 * ratio[i] + 2, n);
    end
    $display("test lo_divs finished");
  endtask

  task automatic test_back_to_hi();
    int n;
    run_conv(1'b1, 2'h1, 12'h7FF, n);
    chk_num("12-bit after 8-bit", 2 * (52 * 16 + 2), n);
    run_conv(1'b1, 2'h1, 12'h001, n);
    chk_num("12-bit length div 16", 52 * 16 + 2, n);
    $display("test back_to_hi finished");
  endtask

  // Reset in mid-conversion, then the next 12-bit run doubles again
  task automatic test_reset_mid();
    int n;
    level = 12'h5A3;
    @(posedge clk);
    start <= 1'b1;
    cfg   <= '{1'b1, 2'h0};
    @(posedge clk);
    start <= 1'b0;
    repeat (50) @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_sig("reset flags", 12'h000, {9'h0, busy, done, sample});
    chk_sig("reset code", 12'h000, dac);
    chk_sig("reset result", 12'h000, result);
    run_conv(1'b1, 2'h0, 12'h5A3, n);
    chk_num("12-bit length after reset", 2 * (52 * 8 + 2), n);
    $display("test reset_mid finished");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_sig("idle flags", 12'h000, {9'h0, busy, done, sample});
    chk_sig("idle code", 12'h000, dac);
    chk_sig("idle result", 12'h000, result);
    test_first_hi();
    test_plain_hi();
    test_reset_mid();
    test_lo_divs();
    test_back_to_hi();
    give_verdict();
  end

  // Run needs about 9200 cycles
  initial begin
    #(12000 * 40);
    $display("CHECK FAILED watchdog expected finish seen hang");
    err_count++;
    give_verdict();
  end
endmodule // tb_adc_conversion_sequencer
